// *** hdl/atf_pkg.sv ***
package atf_pkg;
    // register indices on the task-file port
    localparam logic [3:0] ATF_IDX_DATA_ERR = 4'h1;  // read fault_report, write feature_param
    localparam logic [3:0] ATF_IDX_COUNT = 4'h2;
    localparam logic [3:0] ATF_IDX_SECTOR = 4'h3;
    localparam logic [3:0] ATF_IDX_POS_LO = 4'h4;
    localparam logic [3:0] ATF_IDX_POS_HI = 4'h5;
    localparam logic [3:0] ATF_IDX_UNIT = 4'h6;
    localparam logic [3:0] ATF_IDX_CMD_STAT = 4'h7;  // read condition_flags, write command_code
    localparam logic [3:0] ATF_IDX_CTL_ALT = 4'he;   // read alt_condition_view, write host_control
    // host_control fields
    localparam int ATF_CTL_HOB = 7;
    localparam int ATF_CTL_SOFT_RESET_BIT = 2;
    localparam int ATF_CTL_IEN_N = 1;
    // unit_head_select fields
    localparam int ATF_UH_LBA = 6;
    localparam logic [7:0] ATF_UH_FIXED = 8'ha0;
    // status, error, count and sector reset values, error bit mask and diagnostic opcode
    localparam logic [7:0] ATF_STAT_RESET = 8'h50;
    localparam logic [7:0] ATF_ERR_KEEP = 8'hd6;
    localparam logic [7:0] ATF_DIAG_OK = 8'h01;
    localparam logic [7:0] ATF_DIAG_CMD = 8'h90;
    localparam logic [7:0] ATF_CNT_RESET = 8'h01;
    localparam logic [7:0] ATF_SEC_RESET = 8'h01;
    // revolution pulse: cycles per revolution and pulse length
    localparam int ATF_REV_CYCLES = 208333;
    localparam int ATF_REV_PULSE = 4;

    typedef struct packed {
        logic busy;
        logic ready;
        logic fault;
        logic settled;
        logic xfer_req;
        logic fixed;
        logic rev;
        logic err;
    } atf_status_t;

    // completion report from the drive engine
    typedef struct packed {
        logic        ok;
        logic [7:0]  errors;
        logic [15:0] remaining;
        logic [47:0] lba;
    } atf_done_t;
endpackage

// *** hdl/atf_rev_pulse.sv ***
`timescale 1ns/100ps
module atf_rev_pulse #(
    parameter int PERIOD = atf_pkg::ATF_REV_CYCLES,
    parameter int WIDTH = atf_pkg::ATF_REV_PULSE
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // pulse out
    output logic rev_q
);
    logic [31:0] cnt_q;
    wire logic wrap = (cnt_q == 32'(PERIOD - 1));

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 32'h0;
            rev_q <= 1'b0;
        end else begin
            cnt_q <= wrap ? 32'h0 : cnt_q + 32'h1;
            rev_q <= (cnt_q < 32'(WIDTH));
        end
    end
endmodule

// *** hdl/atf_task_file.sv ***
`timescale 1ns/100ps
//
// Behaviour
// - alternate status read never clears interrupt
// - command starts right after command write
// - LBA bytes rewritten at command end
// - 48-bit: previous byte holds upper address
// - command-block write clears upper byte select
// - held in reset while soft reset set
// - interrupt only if enabled and selected
// - bit 6 selects CHS or LBA
// - head bits updated at completion, unit ignored
// - diagnostic code after reset or diagnostic
// - error layout, bits 5,3,0 zero
// - zero count means 65536
// - status read clears pending interrupt
// - while busy every read returns status
// - ready low after error until status read
// - seek settled frozen after error
// - fault and fixed zero, revolution pulse
// - error flag cleared by next command
module atf_task_file #(
    parameter int REV_CYCLES = atf_pkg::ATF_REV_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // task-file register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // drive engine
    input wire logic power_ready,
    input wire logic unit_selected,
    input wire logic seek_start,
    input wire logic seek_done,
    input wire logic standby,
    input wire logic xfer_req,
    input wire logic cmd_done,
    input wire atf_pkg::atf_done_t done_info,
    input wire logic [7:0] diag_code,
    output logic cmd_start,
    output logic [7:0] cmd_opcode,
    output logic [7:0] feat_q,
    output logic lba_mode,
    output logic [47:0] addr_out,
    output logic [16:0] sectors_req,
    output logic soft_reset,
    // host interrupt
    output logic intrq
);
    import atf_pkg::*;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic wr_feat = reg_wr && reg_addr == ATF_IDX_DATA_ERR;
    wire logic wr_cnt = reg_wr && reg_addr == ATF_IDX_COUNT;
    wire logic wr_sec = reg_wr && reg_addr == ATF_IDX_SECTOR;
    wire logic wr_plo = reg_wr && reg_addr == ATF_IDX_POS_LO;
    wire logic wr_phi = reg_wr && reg_addr == ATF_IDX_POS_HI;
    wire logic wr_unit = reg_wr && reg_addr == ATF_IDX_UNIT;
    wire logic wr_cmd = reg_wr && reg_addr == ATF_IDX_CMD_STAT;
    wire logic wr_ctl = reg_wr && reg_addr == ATF_IDX_CTL_ALT;
    wire logic wr_block = wr_feat | wr_cnt | wr_sec | wr_plo | wr_phi | wr_unit | wr_cmd;
    wire logic rd_stat = reg_rd && reg_addr == ATF_IDX_CMD_STAT;

    logic [7:0] ctl_q;
    logic [15:0] cnt_q, sec_q, plo_q, phi_q;
    logic [7:0] unit_q, err_q, cmd_q;
    logic busy_q, ready_q, settled_q, seek_live_q, errf_q, hold_q, pend_q, start_q;
    logic rev;

    // soft reset bit holds the task-file registers, flags and interrupt in reset; host control, read data and revolution pulse use rst only
    wire logic soft_reset_bit = ctl_q[ATF_CTL_SOFT_RESET_BIT];
    wire logic lrst = rst | soft_reset_bit;
    wire logic upper_byte_select = ctl_q[ATF_CTL_HOB];
    wire logic is_diag = cmd_q == ATF_DIAG_CMD;

    // ------------------------------------------------------------
    // host control (survives soft reset)
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctl_q <= 8'h00;
        end else if (wr_ctl) begin
            ctl_q <= reg_wdata;
        end else if (wr_block) begin
            ctl_q[ATF_CTL_HOB] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // address, count and feature registers
    // ------------------------------------------------------------
    // each count or address write while not busy shifts the last byte into the previous-content byte
    always_ff @(posedge sys_clk or posedge lrst) begin
        if (lrst) begin
            cnt_q <= {8'h00, ATF_CNT_RESET};
            sec_q <= {8'h00, ATF_SEC_RESET};
            plo_q <= 16'h0000;
            phi_q <= 16'h0000;
            unit_q <= 8'h00;
            feat_q <= 8'h00;
            cmd_q <= 8'h00;
        end else if (cmd_done && busy_q) begin
            // completion rewrites address and count
            sec_q <= {done_info.lba[31:24], done_info.lba[7:0]};
            plo_q <= {done_info.lba[39:32], done_info.lba[15:8]};
            phi_q <= {done_info.lba[47:40], done_info.lba[23:16]};
            unit_q[3:0] <= done_info.lba[27:24];
            cnt_q <= done_info.ok ? 16'h0000 : done_info.remaining;
        end else if (!busy_q) begin
            if (wr_cnt) cnt_q <= {cnt_q[7:0], reg_wdata};
            if (wr_sec) sec_q <= {sec_q[7:0], reg_wdata};
            if (wr_plo) plo_q <= {plo_q[7:0], reg_wdata};
            if (wr_phi) phi_q <= {phi_q[7:0], reg_wdata};
            if (wr_unit) unit_q <= reg_wdata;
            if (wr_feat) feat_q <= reg_wdata;
            if (wr_cmd) cmd_q <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // command start and busy
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge lrst) begin
        if (lrst) begin
            start_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            start_q <= wr_cmd && !busy_q;
            if (wr_cmd && !busy_q) begin
                busy_q <= 1'b1;
            end else if (cmd_done) begin
                busy_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // error register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge lrst) begin
        if (lrst) begin
            err_q <= ATF_DIAG_OK;
        end else if (cmd_done && busy_q) begin
            err_q <= is_diag ? diag_code : (done_info.errors & ATF_ERR_KEEP);
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    wire logic fail = cmd_done && busy_q && !done_info.ok;
    // live seek state keeps running; the shown flag freezes from an error
    // until status is read, then shows the live state again
    wire logic seek_live_d = standby ? 1'b1 :
        seek_start ? 1'b0 : seek_done ? 1'b1 : seek_live_q;
    wire logic show_seek = standby || (!fail && (!hold_q || rd_stat));
    always_ff @(posedge sys_clk or posedge lrst) begin
        if (lrst) begin
            ready_q <= 1'b0;
            settled_q <= 1'b1;
            seek_live_q <= 1'b1;
            errf_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            if (wr_cmd && !busy_q) errf_q <= 1'b0;
            else if (fail) errf_q <= 1'b1;
            // error holds ready low and freezes settled; set wins over read
            if (fail) hold_q <= 1'b1;
            else if (rd_stat) hold_q <= 1'b0;
            ready_q <= power_ready && !fail && !(hold_q && !rd_stat);
            seek_live_q <= seek_live_d;
            if (show_seek) settled_q <= seek_live_d;
        end
    end

    atf_rev_pulse #(
        .PERIOD(REV_CYCLES),
        .WIDTH(ATF_REV_PULSE)
    ) u_rev (
        .sys_clk(sys_clk),
        .rst(rst),
        .rev_q(rev)
    );

    atf_status_t stat;
    assign stat.busy = busy_q;
    assign stat.ready = ready_q;
    assign stat.fault = 1'b0;
    assign stat.settled = settled_q;
    assign stat.xfer_req = xfer_req && busy_q;
    assign stat.fixed = 1'b0;
    assign stat.rev = rev;
    assign stat.err = errf_q;

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    // completion sets pending; a status read clears it, set wins
    always_ff @(posedge sys_clk or posedge lrst) begin
        if (lrst) begin
            pend_q <= 1'b0;
        end else if (cmd_done && busy_q) begin
            pend_q <= 1'b1;
        end else if (rd_stat) begin
            pend_q <= 1'b0;
        end
    end
    assign intrq = pend_q && !ctl_q[ATF_CTL_IEN_N] && unit_selected;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            ATF_IDX_DATA_ERR: rd_mux = err_q;
            ATF_IDX_COUNT: rd_mux = upper_byte_select ? cnt_q[15:8] : cnt_q[7:0];
            ATF_IDX_SECTOR: rd_mux = upper_byte_select ? sec_q[15:8] : sec_q[7:0];
            ATF_IDX_POS_LO: rd_mux = upper_byte_select ? plo_q[15:8] : plo_q[7:0];
            ATF_IDX_POS_HI: rd_mux = upper_byte_select ? phi_q[15:8] : phi_q[7:0];
            ATF_IDX_UNIT: rd_mux = unit_q | ATF_UH_FIXED;
            ATF_IDX_CMD_STAT: rd_mux = stat;
            ATF_IDX_CTL_ALT: rd_mux = stat;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= ATF_STAT_RESET;
        end else if (reg_rd) begin
            reg_rdata <= busy_q ? stat : rd_mux;
        end
    end

    // ------------------------------------------------------------
    // engine outputs
    // ------------------------------------------------------------
    wire logic lba = unit_q[ATF_UH_LBA];
    assign cmd_start = start_q;
    assign cmd_opcode = cmd_q;
    assign lba_mode = lba;
    assign soft_reset = soft_reset_bit;
    // unit select bit 4 ignored; head bits unused, 27:24 come from the sector previous-content byte
    assign addr_out = {phi_q[15:8], plo_q[15:8], sec_q[15:8], phi_q[7:0], plo_q[7:0],
        sec_q[7:0]};
    assign sectors_req = (cnt_q == 16'h0000) ? 17'h10000 : {1'b0, cnt_q};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_start_after_cmd: assert property (@(posedge sys_clk) disable iff (lrst)
        (wr_cmd && !busy_q) |=> (cmd_start && busy_q))
        else $error("command write did not start command");
    a_hob_cleared: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_block && !wr_ctl) |=> !ctl_q[ATF_CTL_HOB])
        else $error("upper byte select not cleared");
    a_stat_clears_int: assert property (@(posedge sys_clk) disable iff (lrst)
        (rd_stat && !(cmd_done && busy_q)) |=> !pend_q)
        else $error("status read left interrupt pending");
    a_alt_keeps_int: assert property (@(posedge sys_clk) disable iff (lrst)
        (pend_q && reg_rd && reg_addr == ATF_IDX_CTL_ALT) |=> pend_q)
        else $error("alternate read cleared interrupt");
    a_int_gated: assert property (@(posedge sys_clk) disable iff (lrst)
        intrq |-> (!ctl_q[ATF_CTL_IEN_N] && unit_selected))
        else $error("interrupt while disabled");
    a_busy_reads_stat: assert property (@(posedge sys_clk) disable iff (lrst)
        (reg_rd && busy_q) |=> reg_rdata[7])
        else $error("busy read did not return status");
    a_err_clear_cmd: assert property (@(posedge sys_clk) disable iff (lrst)
        (wr_cmd && !busy_q) |=> !errf_q)
        else $error("error flag survived new command");
    a_ready_low_err: assert property (@(posedge sys_clk) disable iff (lrst)
        fail |=> !ready_q)
        else $error("ready high after error");
    a_fault_zero: assert property (@(posedge sys_clk) disable iff (lrst)
        !stat.fault && !stat.fixed)
        else $error("fault or fixed flag set");
    a_count_zero: assert property (@(posedge sys_clk) disable iff (lrst)
        (cmd_done && busy_q && done_info.ok) |=> cnt_q == 16'h0000)
        else $error("count not zero after success");
    a_addr_writeback: assert property (@(posedge sys_clk) disable iff (lrst)
        (cmd_done && busy_q) |=> (addr_out == $past(done_info.lba)))
        else $error("address not rewritten at completion");
    a_err_layout: assert property (@(posedge sys_clk) disable iff (lrst)
        (cmd_done && busy_q && !is_diag) |=> ((err_q & ~ATF_ERR_KEEP) == 8'h00))
        else $error("reserved error bits set");
    a_ready_back: assert property (@(posedge sys_clk) disable iff (lrst)
        (rd_stat && hold_q && !fail && power_ready) |=> ready_q)
        else $error("ready not restored by status read");
    a_settled_frozen: assert property (@(posedge sys_clk) disable iff (lrst)
        (hold_q && !rd_stat && !standby) |=> $stable(settled_q))
        else $error("seek flag moved while error held");
endmodule

// *** test/ata_task_file_registers_tb.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module ata_task_file_registers_tb;
    import atf_pkg::*;
    logic sys_clk, rst, reg_wr, reg_rd, power_ready, unit_selected, seek_start, seek_done;
    logic standby, xfer_req, cmd_done, cmd_start, lba_mode, soft_reset, intrq, hit;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, diag_code, cmd_opcode, feat_q, d, v;
    logic [47:0] addr_out;
    logic [16:0] sectors_req;
    atf_done_t done_info;
    int n_fail = 0, checked = 0, n_start = 0, seed;
    atf_task_file #(.REV_CYCLES(20)) atf_task_file_inst (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .power_ready(power_ready), .unit_selected(unit_selected),
        .seek_start(seek_start), .seek_done(seek_done), .standby(standby),
        .xfer_req(xfer_req), .cmd_done(cmd_done), .done_info(done_info),
        .diag_code(diag_code), .cmd_start(cmd_start), .cmd_opcode(cmd_opcode),
        .feat_q(feat_q), .lba_mode(lba_mode), .addr_out(addr_out),
        .sectors_req(sectors_req), .soft_reset(soft_reset), .intrq(intrq));
    atf_host_model H (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (cmd_start === 1'b1) n_start++;
    function automatic logic [7:0] stat(input logic r, input logic e);
        return {1'b0, r, 1'b0, 1'b1, 4'h0} | {7'h0, e};
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ----------------------------------------
    // one command from register load to status read
    // ----------------------------------------
    task automatic run_cmd(input logic [7:0] op, input logic [15:0] n, input logic ok,
            input logic [7:0] e, input logic irq);
        logic [47:0] a, fin;
        logic [15:0] rem;
        int s0;
        a = {16'($urandom), 32'($urandom)};
        fin = {16'h0, 32'($urandom)};
        rem = ok ? 16'h0000 : 16'h0005;
        H.wr(ATF_IDX_COUNT, n[15:8]);
        H.wr(ATF_IDX_COUNT, n[7:0]);
        for (int i = 0; i < 3; i++) begin
            H.wr(ATF_IDX_SECTOR + 4'(i), a[8*i+24 +: 8]);
            H.wr(ATF_IDX_SECTOR + 4'(i), a[8*i +: 8]);
        end
        H.wr(ATF_IDX_UNIT, 8'hf0);
        s0 = n_start;
        H.wr(ATF_IDX_CMD_STAT, op);
        @(negedge sys_clk);
        `CHK(n_start, s0 + 1)
        `CHK(cmd_opcode, op)
        `CHK(addr_out, a)
        `CHK(lba_mode, 1'b1)
        `CHK(sectors_req, (n == 16'h0) ? 17'h10000 : {1'b0, n})
        xfer_req = 1'($urandom);
        H.rd(ATF_IDX_POS_LO, d);
        `CHK(d[7], 1'b1)
        `CHK(d[3], xfer_req)
        @(negedge sys_clk);
        cmd_done = 1'b1;
        xfer_req = 1'b0;
        done_info = '{ok: ok, errors: e, remaining: rem, lba: fin};
        @(negedge sys_clk);
        cmd_done = 1'b0;
        seek_start = !ok;
        @(negedge sys_clk);
        seek_start = 1'b0;
        `CHK(intrq, irq)
        for (int i = 0; i < 3; i++) begin
            H.rd(ATF_IDX_SECTOR + 4'(i), d);
            `CHK(d, fin[8*i +: 8])
        end
        H.rd(ATF_IDX_UNIT, d);
        `CHK(d[3:0], fin[27:24])
        H.rd(ATF_IDX_COUNT, d);
        `CHK(d, rem[7:0])
        H.rd(ATF_IDX_DATA_ERR, d);
        `CHK(d, (op == ATF_DIAG_CMD) ? diag_code : (e & ATF_ERR_KEEP))
        H.rd(ATF_IDX_CTL_ALT, d);
        `CHK(d & 8'hfd, stat(ok, !ok))
        `CHK(intrq, irq)
        H.rd(ATF_IDX_CMD_STAT, d);
        `CHK(H.shadow_busy, 1'b0)
        @(negedge sys_clk);
        `CHK(intrq, 1'b0)
        H.rd(ATF_IDX_CTL_ALT, d);
        `CHK(d & 8'hfd, stat(1'b1, !ok) ^ {3'h0, !ok, 4'h0})
        seek_done = 1'b1;
        @(negedge sys_clk);
        seek_done = 1'b0;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = $urandom(24);
        {rst, power_ready, unit_selected} = 3'b111;
        {seek_start, seek_done, standby, cmd_done} = 4'h0;
        xfer_req = 1'b0;
        done_info = '0;
        diag_code = 8'($urandom_range(2, 5));
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        H.rd(ATF_IDX_CMD_STAT, d);
        `CHK(d & 8'hfd, stat(1'b1, 1'b0))
        H.rd(ATF_IDX_DATA_ERR, d);
        `CHK(d, ATF_DIAG_OK)
        for (int s = 1; s >= 0; s--) begin
            @(negedge sys_clk);
            {seek_start, seek_done} = {s[0], !s[0]};
            @(negedge sys_clk);
            {seek_start, seek_done} = 2'b00;
            H.rd(ATF_IDX_CTL_ALT, d);
            `CHK(d[4], !s[0])
        end
        standby = 1'b1;
        @(negedge sys_clk);
        seek_start = 1'b1;
        @(negedge sys_clk);
        {seek_start, standby} = 2'b00;
        H.rd(ATF_IDX_CTL_ALT, d);
        `CHK(d[4], 1'b1)
        hit = 1'b0;
        for (int i = 0; i < 15; i++) begin
            H.rd(ATF_IDX_CTL_ALT, d);
            hit = hit | d[1];
            `CHK(d[5] | d[2], 1'b0)
        end
        `CHK(hit, 1'b1)
        run_cmd(8'($urandom_range(32, 143)), 16'h0, 1'b0, 8'($urandom), 1'b1);
        run_cmd(8'($urandom_range(32, 143)), 16'($urandom), 1'b1, 8'h00, 1'b1);
        v = 8'($urandom);
        H.wr(ATF_IDX_COUNT, v);
        H.wr(ATF_IDX_COUNT, ~v);
        H.wr(ATF_IDX_CTL_ALT, 8'h80);
        H.rd(ATF_IDX_COUNT, d);
        `CHK(d, v)
        H.wr(ATF_IDX_SECTOR, 8'h01);
        H.rd(ATF_IDX_COUNT, d);
        `CHK(d, ~v)
        H.wr(ATF_IDX_CTL_ALT, 8'h02);
        run_cmd(8'h25, 16'h0010, 1'b1, 8'h00, 1'b0);
        H.wr(ATF_IDX_CTL_ALT, 8'h00);
        unit_selected = 1'b0;
        run_cmd(8'h25, 16'h0001, 1'b1, 8'h00, 1'b0);
        unit_selected = 1'b1;
        run_cmd(ATF_DIAG_CMD, 16'h0001, 1'b1, 8'h00, 1'b1);
        H.wr(ATF_IDX_CTL_ALT, 8'h04);
        `CHK(soft_reset, 1'b1)
        repeat (125) @(negedge sys_clk);
        H.wr(ATF_IDX_CTL_ALT, 8'h00);
        `CHK(soft_reset, 1'b0)
        H.rd(ATF_IDX_COUNT, d);
        `CHK(d, ATF_CNT_RESET)
        H.rd(ATF_IDX_DATA_ERR, d);
        `CHK(d, ATF_DIAG_OK)
        summarize();
    end
    // hang guard
    initial begin
        #2000000;
        n_fail++;
        summarize();
    end
endmodule

// *** test/atf_host_model.sv ***
`timescale 1ns/100ps
module atf_host_model (
    // clock
    input wire logic sys_clk,
    // task-file port
    output logic [3:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    logic shadow_busy = 1'b0;
    logic last_soft_reset_bit = 1'b0;
    initial begin
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // ----------------------------------------
    // register cycles, taken at the next rising edge
    // ----------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        if (a == atf_pkg::ATF_IDX_CMD_STAT ||
                (a == atf_pkg::ATF_IDX_CTL_ALT && d[atf_pkg::ATF_CTL_SOFT_RESET_BIT] != last_soft_reset_bit))
            shadow_busy = 1'b1;
        if (a == atf_pkg::ATF_IDX_CTL_ALT)
            last_soft_reset_bit = d[atf_pkg::ATF_CTL_SOFT_RESET_BIT];
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
        if (a == atf_pkg::ATF_IDX_CMD_STAT)
            shadow_busy = d[7];
    endtask
endmodule
